// ==== logic/ldfc_defines.svh ====
// Offsets, field positions, reset values and timing counts for the laser drive block.
// Assumes a 40 MHz clock and 32-bit APB on the loader side.
`ifndef LDFC_DEFINES_SVH
`define LDFC_DEFINES_SVH
`define LDFC_IMAGE_BYTES 1986
`define LDFC_ADDR_CONFIG 8'h0A
`define LDFC_ADDR_PWR_A 8'h1A
`define LDFC_ADDR_PWR_B 8'h1B
`define LDFC_ADDR_BIN 8'h2C
`define LDFC_CFG_MODE_BIT 0
`define LDFC_CFG_RESET 8'h00
`define LDFC_FRAME_CYCLES 16'h1388
`define LDFC_EXPOSE_CYCLES 16'h03E8
`define LDFC_TEST_CYCLES 8'h10
`define LDFC_APB_CTRL 12'h000
`define LDFC_APB_STATUS 12'h004
`define LDFC_APB_MASK 12'h008
`define LDFC_APB_WDATA 12'h00C
`define LDFC_APB_REGWR 12'h010
`define LDFC_APB_REGRD 12'h014
`define LDFC_ST_DONE 0
`define LDFC_ST_FAULT 1
`endif

// ==== logic/ldfc_pkg.sv ====
// Types shared by both ends of the laser drive link.
// Assumes the defines header is compiled alongside.
package ldfc_pkg;
  typedef enum logic [2:0] {
    LDFC_BOOT = 3'b001,
    LDFC_RUN = 3'b010,
    LDFC_TEST = 3'b100
  } ldfc_dev_state_t;
  typedef enum logic [2:0] {
    LDFC_IDLE = 3'b001,
    LDFC_LOAD = 3'b010,
    LDFC_DONE = 3'b100
  } ldfc_host_state_t;
endpackage

// ==== logic/ldfc_link_if.sv ====
// Link between the loader and the laser drive device.
// Assumes one clock shared by both ends.
interface ldfc_link_if;
  logic burstValid;
  logic [7:0] burstData;
  logic regWrite;
  logic [7:0] regAddr;
  logic [7:0] regData;
  logic [7:0] regRdata;
  logic loaded;
  logic faulted;
  logic power_down_n;
  modport device (input burstValid, input burstData, input regWrite, input regAddr,
    input regData, input power_down_n, output regRdata, output loaded, output faulted);
  modport host (output burstValid, output burstData, output regWrite, output regAddr,
    output regData, output power_down_n, input regRdata, input loaded, input faulted);
endinterface

// ==== logic/ldfc_device.sv ====
// Laser drive and fault control end: program store, drive mode, fault cut-off, self test.
// Assumes the loader obeys the link and that fault sense inputs are synchronous.
//
// Summary of operation
// - Device accepts program download after every reset.
// - Image is exactly 1986 bytes, all stored.
// - Continuous mode: laser on unless powered down.
// - Gated mode: laser on only during exposure.
// - One config bit selects mode; gated by default.
// - Controller keeps gated mode except calibration.
// - Supply enable low normally, high on fault.
// - Short to ground disables laser current source.
// - Writing power config A starts a self test.
// - Test checks short ground, supply, detector.
// - Controller writes safe power values.
// - Calibrate at full duty, then trim power.
//
// Decided for this implementation: register access over APB.
`include "ldfc_defines.svh"
module ldfc_device (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Link to the loader.
  ldfc_link_if.device link,
  // Analogue fault senses.
  input wire logic rbinShortGnd,
  input wire logic laserShortGnd,
  input wire logic laserShortVdd,
  input wire logic detectorOk,
  // Laser controls.
  output logic laserCurrentOn,
  output logic laser_supply_enable_n,
  output logic [7:0] laserPowerCfgA,
  output logic [7:0] laserPowerCfgB
);
  logic [7:0] progMem [0:`LDFC_IMAGE_BYTES-1];
  logic [10:0] loadCount;
  ldfc_pkg::ldfc_dev_state_t state;
  logic [7:0] configBits;
  logic [7:0] binMatch;
  logic [15:0] frameCount;
  logic [7:0] testCount;
  logic testFail;
  logic faultLatched;
  logic loadedReg;
  logic [7:0] rdataReg;
  // Written into memory once the loader presents each byte.
  wire storeByte = (state == ldfc_pkg::LDFC_BOOT) && link.burstValid;
  wire lastByte = storeByte && (loadCount == 11'(`LDFC_IMAGE_BYTES - 1));
  wire running = (state != ldfc_pkg::LDFC_BOOT);
  wire writeCfg = running && link.regWrite && (link.regAddr == `LDFC_ADDR_CONFIG);
  wire writePwrA = running && link.regWrite && (link.regAddr == `LDFC_ADDR_PWR_A);
  wire writePwrB = running && link.regWrite && (link.regAddr == `LDFC_ADDR_PWR_B);
  wire writeBin = running && link.regWrite && (link.regAddr == `LDFC_ADDR_BIN);
  wire continuousMode = configBits[`LDFC_CFG_MODE_BIT];
  wire exposing = (frameCount < `LDFC_EXPOSE_CYCLES);
  // A detector that fails its own check is treated as a fault: failing safe beats
  // trusting a monitor that might never fire.
  wire testBad = laserShortGnd || laserShortVdd || !detectorOk;
  wire liveFault = rbinShortGnd || laserShortGnd;
  wire testing = (state == ldfc_pkg::LDFC_TEST);
  wire startTest = (state == ldfc_pkg::LDFC_RUN) && writePwrA;
  wire driveWanted = running && !testing && link.power_down_n &&
    (continuousMode || exposing);
  wire [7:0] next_rdata = (link.regAddr == `LDFC_ADDR_CONFIG) ? configBits :
    (link.regAddr == `LDFC_ADDR_PWR_A) ? laserPowerCfgA :
    (link.regAddr == `LDFC_ADDR_PWR_B) ? laserPowerCfgB :
    (link.regAddr == `LDFC_ADDR_BIN) ? binMatch : 8'h00;

  assign link.loaded = loadedReg;
  assign link.regRdata = rdataReg;
  assign link.faulted = laser_supply_enable_n;

  always_ff @(posedge clk) begin
    if (storeByte) begin
      progMem[loadCount] <= link.burstData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ldfc_pkg::LDFC_BOOT;
    end else begin
      case (state)
        ldfc_pkg::LDFC_BOOT: begin
          if (lastByte) begin
            state <= ldfc_pkg::LDFC_RUN;
          end
        end
        ldfc_pkg::LDFC_RUN: begin
          if (startTest) begin
            state <= ldfc_pkg::LDFC_TEST;
          end
        end
        ldfc_pkg::LDFC_TEST: begin
          if (testCount == 8'h01) begin
            state <= ldfc_pkg::LDFC_RUN;
          end
        end
        default: state <= ldfc_pkg::LDFC_BOOT;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loadCount <= 11'h000;
    end else if (storeByte) begin
      loadCount <= loadCount + 11'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loadedReg <= 1'b0;
    end else if (lastByte) begin
      loadedReg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      testCount <= 8'h00;
    end else if (startTest) begin
      testCount <= `LDFC_TEST_CYCLES;
    end else if (testing) begin
      testCount <= testCount - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      configBits <= `LDFC_CFG_RESET;
    end else if (writeCfg) begin
      configBits <= link.regData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      laserPowerCfgA <= 8'h00;
    end else if (writePwrA) begin
      laserPowerCfgA <= link.regData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      laserPowerCfgB <= 8'h00;
    end else if (writePwrB) begin
      laserPowerCfgB <= link.regData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      binMatch <= 8'h00;
    end else if (writeBin) begin
      binMatch <= link.regData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdataReg <= 8'h00;
    end else begin
      rdataReg <= next_rdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frameCount <= 16'h0000;
    end else if (frameCount == `LDFC_FRAME_CYCLES - 16'h0001) begin
      frameCount <= 16'h0000;
    end else begin
      frameCount <= frameCount + 16'h0001;
    end
  end

  // The fault latch holds until reset, so a short that clears by itself never
  // re-arms the laser unseen.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      faultLatched <= 1'b0;
    end else if (liveFault || testFail) begin
      faultLatched <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      testFail <= 1'b0;
    end else if (testing && testBad) begin
      testFail <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      laserCurrentOn <= 1'b0;
    end else begin
      laserCurrentOn <= driveWanted && !faultLatched && !liveFault;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      laser_supply_enable_n <= 1'b0;
    end else begin
      laser_supply_enable_n <= faultLatched || liveFault;
    end
  end
endmodule // ldfc_device

// ==== logic/ldfc_host.sv ====
// Loader end: downloads the program image and forwards APB orders as register writes.
// Assumes an APB master on the software side and a 1986-byte image in its own array.
`include "ldfc_defines.svh"
module ldfc_host (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt.
  output logic irq,
  // Link to the device.
  ldfc_link_if.host link
);
  logic [7:0] image [0:`LDFC_IMAGE_BYTES-1];
  ldfc_pkg::ldfc_host_state_t state;
  logic [10:0] sendCount;
  logic [7:0] imgData;
  logic [1:0] status;
  logic [1:0] mask;
  logic start;
  logic powerUp;
  logic burstValid;
  logic regWrite;
  logic [7:0] regAddr;
  logic [7:0] regData;
  logic doneSeen;
  logic faultSeen;
  wire apbAccess = psel && penable;
  // Writes land only on the completing edge, so a waited access never writes twice.
  wire apbWrite = apbAccess && pwrite && pready;
  wire hitCtrl = (paddr == `LDFC_APB_CTRL);
  wire hitStatus = (paddr == `LDFC_APB_STATUS);
  wire hitMask = (paddr == `LDFC_APB_MASK);
  wire hitWdata = (paddr == `LDFC_APB_WDATA);
  wire hitRegwr = (paddr == `LDFC_APB_REGWR);
  wire hitRegrd = (paddr == `LDFC_APB_REGRD);
  wire mapped = hitCtrl || hitStatus || hitMask || hitWdata || hitRegwr || hitRegrd;
  wire readStatus = apbAccess && !pwrite && hitStatus;
  wire loading = (state == ldfc_pkg::LDFC_LOAD);
  wire sendLast = loading && (sendCount == 11'(`LDFC_IMAGE_BYTES - 1));
  wire doneEvent = link.loaded && !doneSeen;
  wire faultEvent = link.faulted && !faultSeen;
  wire [1:0] events = {faultEvent, doneEvent};
  wire [31:0] next_prdata = hitCtrl ? {30'h0000_0000, powerUp, start} :
    hitStatus ? {30'h0000_0000, status} :
    hitMask ? {30'h0000_0000, mask} :
    hitRegrd ? {24'h00_0000, link.regRdata} : 32'h0000_0000;

  assign link.burstValid = burstValid;
  assign link.burstData = imgData;
  assign link.regWrite = regWrite;
  assign link.regAddr = regAddr;
  assign link.regData = regData;
  assign link.power_down_n = powerUp;

  always_ff @(posedge clk) begin
    if (apbWrite && hitWdata) begin
      image[pwdata[26:16]] <= pwdata[7:0];
    end
    imgData <= image[sendCount];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ldfc_pkg::LDFC_IDLE;
      sendCount <= 11'h000;
      burstValid <= 1'b0;
    end else begin
      burstValid <= loading;
      case (state)
        ldfc_pkg::LDFC_IDLE: begin
          if (start) begin
            state <= ldfc_pkg::LDFC_LOAD;
          end
        end
        ldfc_pkg::LDFC_LOAD: begin
          sendCount <= sendCount + 11'h001;
          if (sendLast) begin
            state <= ldfc_pkg::LDFC_DONE;
          end
        end
        ldfc_pkg::LDFC_DONE: state <= ldfc_pkg::LDFC_DONE;
        default: state <= ldfc_pkg::LDFC_IDLE;
      endcase
    end
  end

  // Register orders pass straight through; software owns power values and calibration.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start <= 1'b0;
      powerUp <= 1'b1;
      mask <= 2'b00;
      regWrite <= 1'b0;
      regAddr <= 8'h00;
      regData <= 8'h00;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      regWrite <= apbWrite && hitRegwr && link.loaded;
      pready <= apbAccess && !pready;
      pslverr <= apbAccess && !pready && !mapped;
      prdata <= next_prdata;
      if (apbWrite && hitCtrl) begin
        start <= pwdata[0];
        powerUp <= pwdata[1];
      end
      if (apbWrite && hitMask) begin
        mask <= pwdata[1:0];
      end
      if (apbWrite && (hitRegwr || hitRegrd)) begin
        regAddr <= pwdata[15:8];
        regData <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= 2'b00;
      doneSeen <= 1'b0;
      faultSeen <= 1'b0;
      irq <= 1'b0;
    end else begin
      doneSeen <= link.loaded;
      faultSeen <= link.faulted;
      status <= (readStatus && pready ? 2'b00 : status) | events;
      irq <= |(status & mask);
    end
  end
endmodule // ldfc_host

// ==== verification/ldfc_link_assertions.sv ====
// Checker beside the link: image count, drive modes, fault cut-off and self test.
// Assumes one clock, with the device's laser pins wired in beside the link signals.
`include "ldfc_defines.svh"
module ldfc_link_assertions (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Link signals.
  input wire logic burstValid,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regData,
  input wire logic loaded,
  input wire logic power_down_n,
  // Laser and fault sense pins of the device end.
  input wire logic laserCurrentOn,
  input wire logic laser_supply_enable_n,
  input wire logic rbinShortGnd,
  input wire logic laserShortGnd
);
  logic contMode;
  logic modeSeen;
  logic [11:0] byteCnt;
  logic [15:0] onRun;
  wire cfgWr = regWrite && loaded && regAddr == `LDFC_ADDR_CONFIG;
  wire pwrAWr = regWrite && loaded && regAddr == `LDFC_ADDR_PWR_A;
  // The run length restarts in continuous mode and one cycle after it, since the laser pin
  // lags the mode bit by a cycle; a mode switch then never trips the gated bound.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      contMode <= 1'h0;
      modeSeen <= 1'h0;
      byteCnt <= 12'h000;
      onRun <= 16'h0000;
    end else begin
      if (cfgWr) contMode <= regData[`LDFC_CFG_MODE_BIT];
      modeSeen <= contMode;
      if (burstValid && !loaded) byteCnt <= byteCnt + 12'h001;
      onRun <= (laserCurrentOn && !contMode && !modeSeen) ? onRun + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_reset_clears_link: assert property ($rose(rst_n) |-> !loaded && !laser_supply_enable_n)
    else $error("link or supply not clear after reset");
  a_loaded_holds: assert property (loaded |=> loaded)
    else $error("loaded dropped");
  a_image_count: assert property ($rose(loaded) |-> byteCnt == `LDFC_IMAGE_BYTES)
    else $error("wrong image byte count");
  a_fault_cuts_laser: assert property ((rbinShortGnd || laserShortGnd) |=> !laserCurrentOn && laser_supply_enable_n)
    else $error("fault did not cut laser");
  a_fault_stays_latched: assert property (laser_supply_enable_n |=> laser_supply_enable_n && !laserCurrentOn)
    else $error("fault released");
  a_powerdown_dark: assert property (contMode && !power_down_n |=> !laserCurrentOn)
    else $error("laser on in power down");
  a_gated_on_bound: assert property (!contMode |-> onRun <= `LDFC_EXPOSE_CYCLES)
    else $error("gated laser on too long");
  a_test_laser_dark: assert property (pwrAWr |-> ##2 !laserCurrentOn [*8])
    else $error("laser on during self test");
  cover property ($rose(loaded));
  cover property (contMode && !power_down_n);
  cover property ($rose(laser_supply_enable_n));
endmodule // ldfc_link_assertions

// ==== verification/tb_laser_drive_fault_control.sv ====
// Bench joining host and device over the link, driven through APB.
// Assumes the design files and the defines header are compiled first.
`include "ldfc_defines.svh"
module tb_laser_drive_fault_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, irq, laserOn, laser_supply_enable_n, errBit;
  logic rbinShortGnd = 1'h0, laserShortGnd = 1'h0, laserShortVdd = 1'h0, detectorOk = 1'h1;
  logic [7:0] cfgA, cfgB;
  logic [11:0] bytes;
  int errors = 0, num_checks = 0, n;
  ldfc_link_if link ();
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (!rst_n) bytes <= 12'h000;
    else if (link.burstValid && !link.loaded) bytes <= bytes + 12'h001;
  end
  ldfc_host u_ldfc_host (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .link(link));
  ldfc_device u_ldfc_device (.clk(clk), .rst_n(rst_n), .link(link),
    .rbinShortGnd(rbinShortGnd), .laserShortGnd(laserShortGnd), .laserShortVdd(laserShortVdd),
    .detectorOk(detectorOk), .laserCurrentOn(laserOn),
    .laser_supply_enable_n(laser_supply_enable_n), .laserPowerCfgA(cfgA), .laserPowerCfgB(cfgB));
  ldfc_link_assertions u_ldfc_link_assertions (.clk(clk), .rst_n(rst_n),
    .burstValid(link.burstValid), .regWrite(link.regWrite), .regAddr(link.regAddr),
    .regData(link.regData), .loaded(link.loaded), .power_down_n(link.power_down_n),
    .laserCurrentOn(laserOn), .laser_supply_enable_n(laser_supply_enable_n),
    .rbinShortGnd(rbinShortGnd), .laserShortGnd(laserShortGnd));
  task automatic complete_run();
    if (errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask
  // One idle cycle after each transfer keeps the strobes from being driven twice in a step.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      errors++;
      complete_run();
    end
    rd = prdata;
    errBit = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic devWr(input logic [7:0] a, input logic [7:0] d);
    apb(1'h1, `LDFC_APB_REGWR, {16'h0000, a, d});
    cyc(3);
  endtask
  task automatic doReset(input logic m);
    rst_n <= 1'h0;
    rbinShortGnd <= 1'h0;
    laserShortGnd <= 1'h0;
    laserShortVdd <= 1'h0;
    detectorOk <= 1'h1;
    cyc(10);
    chk({laserOn, laser_supply_enable_n, link.loaded}, 32'h0000_0000);
    rst_n <= 1'h1;
    cyc(1);
    apb(1'h1, `LDFC_APB_MASK, {31'h0000_0000, m});
    apb(1'h1, `LDFC_APB_CTRL, 32'h0000_0003);
    n = 0;
    while (link.loaded !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) begin
      errors++;
      complete_run();
    end
    cyc(2);
    chk(bytes, `LDFC_IMAGE_BYTES);
    chk(irq, m);
    apb(1'h0, `LDFC_APB_STATUS, 32'h0000_0000);
    chk(rd[`LDFC_ST_DONE], 32'h0000_0001);
    cyc(1);
    chk(irq, 32'h0000_0000);
    apb(1'h0, `LDFC_APB_STATUS, 32'h0000_0000);
    chk(rd[`LDFC_ST_DONE], 32'h0000_0000);
  endtask
  task automatic sc_access();
    apb(1'h0, 12'h0FC, 32'h0000_0000);
    chk(errBit, 32'h0000_0001);
    devWr(`LDFC_ADDR_PWR_B, 8'h5A);
    apb(1'h1, `LDFC_APB_REGRD, {16'h0000, `LDFC_ADDR_PWR_B, 8'h00});
    apb(1'h0, `LDFC_APB_REGRD, 32'h0000_0000);
    apb(1'h0, `LDFC_APB_REGRD, 32'h0000_0000);
    chk(rd[7:0], 32'h0000_005A);
    chk(cfgB, 32'h0000_005A);
  endtask
  task automatic sc_gated();
    n = 0;
    repeat (5000) begin
      @(posedge clk);
      n += int'(laserOn);
    end
    chk(32'(n), `LDFC_EXPOSE_CYCLES);
  endtask
  task automatic sc_cont();
    devWr(`LDFC_ADDR_CONFIG, 8'h01);
    n = 0;
    repeat (100) begin
      @(posedge clk);
      n += int'(laserOn);
    end
    chk(32'(n), 32'h0000_0064);
    apb(1'h1, `LDFC_APB_CTRL, 32'h0000_0000);
    cyc(3);
    chk(laserOn, 32'h0000_0000);
    apb(1'h1, `LDFC_APB_CTRL, 32'h0000_0002);
    cyc(3);
    chk(laserOn, 32'h0000_0001);
    devWr(`LDFC_ADDR_CONFIG, 8'h00);
  endtask
  task automatic sc_selftest();
    for (int k = 0; k < 2; k++) begin
      devWr(`LDFC_ADDR_CONFIG, 8'h01);
      devWr(`LDFC_ADDR_PWR_A, 8'h40);
      chk(laserOn, 32'h0000_0000);
      cyc(30);
      chk({laserOn, laser_supply_enable_n, cfgA}, 32'h0000_0240);
      laserShortVdd <= (k == 0);
      detectorOk <= (k == 0);
      devWr(`LDFC_ADDR_PWR_A, 8'h41);
      cyc(30);
      chk({laserOn, laser_supply_enable_n}, 32'h0000_0001);
      doReset(k == 1);
    end
  endtask
  task automatic sc_fault();
    for (int k = 0; k < 2; k++) begin
      devWr(`LDFC_ADDR_CONFIG, 8'h01);
      rbinShortGnd <= (k == 0);
      laserShortGnd <= (k == 1);
      cyc(2);
      chk({laserOn, laser_supply_enable_n}, 32'h0000_0001);
      rbinShortGnd <= 1'h0;
      laserShortGnd <= 1'h0;
      cyc(3);
      chk(laser_supply_enable_n, 32'h0000_0001);
      apb(1'h1, `LDFC_APB_MASK, 32'h0000_0002);
      cyc(1);
      chk(irq, 32'h0000_0001);
      apb(1'h0, `LDFC_APB_STATUS, 32'h0000_0000);
      chk(rd[`LDFC_ST_FAULT], 32'h0000_0001);
      doReset(1'h1);
    end
  endtask
  initial begin
    doReset(1'h1);
    sc_access();
    sc_gated();
    sc_cont();
    sc_gated();
    sc_selftest();
    sc_fault();
    complete_run();
  end
endmodule // tb_laser_drive_fault_control
